// File: drive_cfg_if.sv
// Carrier between the register block and the drive current decoder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface drive_cfg_if;
  logic [1:0] code;     // Nominal current code
  logic       doubler;  // Current doubling request
  logic [4:0] half_ma;  // Resulting current in half milliamps

  modport src (output code, output doubler, input half_ma);
  modport dec (input code, input doubler, output half_ma);
endinterface

// File: link_clock_source.sv
// Behavioural model of the receiver side bit clock.
// Assumes the bench raises run only while a frame is on the link.
`timescale 1ns/1ps
module link_clock_source (
  input  wire logic run,      // High while a frame is on the link
  output logic      link_clk  // Receiver bit clock, 64 ns period
);
  ////////////////////////////////////////////////////////////////////////////
  // Odd start offset keeps the edges unrelated to aclk; the clock
  // stands still between frames instead of running free
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever begin
      #32;
      if (run) begin
        link_clk = ~link_clk;
      end
    end
  end
endmodule // link_clock_source

// File: link_edge_sync.sv
// Samples the receiver-side bit clock and reports its edges.
// Assumes the link clock is asynchronous and much slower than aclk.
`timescale 1ns/1ps
module link_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic link_clk,
  output logic      rise,
  output logic      fall
);
  logic sync1;      // First stage, read only by sync2
  logic sync2;      // Second stage
  logic sync3;      // Delayed copy for edge finding
  logic next_sync1;
  logic next_sync2;
  logic next_sync3;

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the synchroniser chain
  always_comb begin
    next_sync1 = link_clk;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  // Registers, cleared synchronously
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end

  // Edge pulses come from the settled stages only
  assign rise = sync2 & ~sync3;
  assign fall = ~sync2 & sync3;
endmodule // link_edge_sync

// File: output_drive_decode.sv
// Decodes an output buffer current code and doubler into half milliamps.
// Assumes code and doubler come from flip-flops on the same clock.
`timescale 1ns/1ps
module output_drive_decode
  import serial_output_format_pkg::*;
(
  drive_cfg_if.dec drv
);
  logic [4:0] nominal;  // Current before doubling

  ////////////////////////////////////////////////////////////////////////////
  // Code to nominal current, then optional doubling
  always_comb begin
    case (drv.code)
      2'h0:    nominal = CUR_CODE0;
      2'h1:    nominal = CUR_CODE1;
      2'h2:    nominal = CUR_CODE2;
      default: nominal = CUR_CODE3;
    endcase
    // Largest nominal is 4 mA, so doubled still fits five bits
    drv.half_ma = drv.doubler ? {nominal[3:0], 1'b0} : nominal;
  end
endmodule // output_drive_decode

// File: serial_output_format_config.sv
// Output format and output buffer drive registers with AXI4-Lite access.
// Assumes parallel control pins and the link clock are asynchronous.
`timescale 1ns/1ps
module serial_output_format_config
  import serial_output_format_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Parallel control pins and receiver bit clock
  input  wire logic [PIN_W-1:0]  format_pins,
  input  wire logic              link_clk,
  // Effective serializer settings
  output logic                   two_wire,
  output logic                   sdr_bit_clock,
  output logic                   serialize_16,
  output logic                   capture_rising,
  output logic                   coarse_gain_high,
  output logic                   lsb_first,
  output logic                   bitwise_split,
  // Output buffer settings
  output logic [4:0]             data_drive_half_ma,
  output logic [4:0]             clock_drive_half_ma,
  output logic [TERM_N-1:0]      clock_term_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [10:0]       format_reg;       // Output format register
  logic [10:0]       drive_reg;        // Output buffer drive register
  logic [10:0]       next_format_reg;
  logic [10:0]       next_drive_reg;
  logic              link_seen;        // Sticky: bit clock edges observed
  logic              next_link_seen;
  logic [PIN_W-1:0]  pins_meta;        // First pin stage, read by pins_sync
  logic [PIN_W-1:0]  pins_sync;        // Second pin stage
  logic              aw_held;          // Write address captured
  logic              w_held;           // Write data captured
  logic [7:0]        aw_index;
  logic [10:0]       w_data;
  logic [1:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              next_aw_held;
  logic              next_w_held;
  logic [7:0]        next_aw_index;
  logic [10:0]       next_w_data;
  logic [1:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic [7:0]        eff_format;       // Register or pins, per override
  logic [10:0]       wr_mask;          // Byte lanes turned into bit mask
  logic              do_write;         // Both halves of a write present
  logic              soft_reset;       // One-cycle software reset
  logic [7:0]        ar_index;
  logic              link_rise;
  logic              link_fall;
  logic [6:0]        next_fmt_out;
  logic [TERM_N-1:0] next_term;
  logic [TERM_N-1:0] term_bits;

  drive_cfg_if data_drv ();
  drive_cfg_if clock_drv ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: two flops before any logic looks at the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= format_pins;
      pins_sync <= pins_meta;
    end
  end

  // Receiver bit clock edge finder
  link_edge_sync u_link (
    .aclk    (aclk),
    .aresetn (aresetn),
    .link_clk(link_clk),
    .rise    (link_rise),
    .fall    (link_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign do_write      = aw_held && w_held;
  assign soft_reset    = do_write && (aw_index == IDX_SOFT_RESET)
                         && w_strb[1] && w_data[SRST_BIT];

  always_comb begin
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_index = aw_index;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    // Capture address; drop the two byte-offset bits
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held  = 1'b1;
      next_aw_index = s_axi_awaddr[9:2];
    end
    // Capture data; only lanes 0 and 1 hold register bits
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[10:0];
      next_w_strb = s_axi_wstrb[1:0];
    end
    // Both present: perform the write and answer
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      case (aw_index)
        IDX_SOFT_RESET, IDX_FORMAT, IDX_DRIVE, IDX_STATUS:
          next_bresp = RESP_OKAY;
        default:
          next_bresp = RESP_SLVERR;  // Unmapped address
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  assign wr_mask = {{3{w_strb[1]}}, {8{w_strb[0]}}};

  always_comb begin
    next_format_reg = format_reg;
    next_drive_reg  = drive_reg;
    if (soft_reset) begin
      // Software reset clears both registers like hardware reset
      next_format_reg = FORMAT_RESET;
      next_drive_reg  = DRIVE_RESET;
    end else if (do_write && aw_index == IDX_FORMAT) begin
      // Reserved bits stay zero
      next_format_reg = (format_reg & ~(wr_mask & FORMAT_WMASK))
                      | (w_data & wr_mask & FORMAT_WMASK);
    end else if (do_write && aw_index == IDX_DRIVE) begin
      next_drive_reg = (drive_reg & ~(wr_mask & DRIVE_WMASK))
                     | (w_data & wr_mask & DRIVE_WMASK);
    end
  end

  // Sticky link activity flag; an edge wins over a clear
  always_comb begin
    next_link_seen = link_seen;
    if (soft_reset) begin
      next_link_seen = 1'b0;
    end
    if (link_rise || link_fall) begin
      next_link_seen = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign ar_index      = s_axi_araddr[9:2];

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (ar_index)
        IDX_FORMAT:     next_rdata = {21'h00000, format_reg};
        IDX_DRIVE:      next_rdata = {21'h00000, drive_reg};
        // Soft reset self-clears, so it always reads zero
        IDX_SOFT_RESET: next_rdata = 32'h00000000;
        IDX_STATUS:     next_rdata = {22'h00000, link_seen,
                                      format_reg[FMT_OVERRIDE], eff_format};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective format: pins rule unless the override bit is set
  assign eff_format = format_reg[FMT_OVERRIDE] ? format_reg[7:0]
                                               : pins_sync;

  // Decoded settings; dependent bits only act in their mode
  always_comb begin
    next_fmt_out[0] = eff_format[FMT_TWO_WIRE];
    next_fmt_out[1] = eff_format[FMT_TWO_WIRE]
                      & eff_format[FMT_SDR];
    next_fmt_out[2] = eff_format[FMT_SER16];
    // Capture edge only means something with an SDR clock
    next_fmt_out[3] = next_fmt_out[1] & eff_format[FMT_RISING];
    next_fmt_out[4] = eff_format[FMT_GAIN];
    next_fmt_out[5] = eff_format[FMT_LSB_FIRST];
    next_fmt_out[6] = eff_format[FMT_TWO_WIRE]
                      & eff_format[FMT_BITWISE];
  end

  // Drive current decoders share one module
  assign data_drv.code     = drive_reg[DRV_DATA_LO+1:DRV_DATA_LO];
  assign data_drv.doubler  = drive_reg[DRV_DATA_DBL];
  assign clock_drv.code    = drive_reg[DRV_CLK_LO+1:DRV_CLK_LO];
  assign clock_drv.doubler = drive_reg[DRV_CLK_DBL];

  output_drive_decode u_data_drive (
    .drv(data_drv)
  );

  output_drive_decode u_clock_drive (
    .drv(clock_drv)
  );

  // Each termination bit switches its own resistor; several in parallel
  assign term_bits = drive_reg[DRV_TERM_LO+TERM_N-1:DRV_TERM_LO];
  genvar gi;
  generate
    for (gi = 0; gi < TERM_N; gi++) begin : g_term
      assign next_term[gi] = term_bits[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State registers; hardware reset clears everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      format_reg <= FORMAT_RESET;
      drive_reg  <= DRIVE_RESET;
      link_seen  <= 1'b0;
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      aw_index   <= 8'h00;
      w_data     <= 11'h000;
      w_strb     <= 2'h0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      rvalid     <= 1'b0;
      rdata      <= 32'h00000000;
      rresp      <= RESP_OKAY;
    end else begin
      format_reg <= next_format_reg;
      drive_reg  <= next_drive_reg;
      link_seen  <= next_link_seen;
      aw_held    <= next_aw_held;
      w_held     <= next_w_held;
      aw_index   <= next_aw_index;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rdata      <= next_rdata;
      rresp      <= next_rresp;
    end
  end

  // Output flops: settings change one cycle after their source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_wire            <= 1'b0;
      sdr_bit_clock       <= 1'b0;
      serialize_16        <= 1'b0;
      capture_rising      <= 1'b0;
      coarse_gain_high    <= 1'b0;
      lsb_first           <= 1'b0;
      bitwise_split       <= 1'b0;
      data_drive_half_ma  <= CUR_CODE0;
      clock_drive_half_ma <= CUR_CODE0;
      clock_term_enable   <= '0;
    end else begin
      two_wire            <= next_fmt_out[0];
      sdr_bit_clock       <= next_fmt_out[1];
      serialize_16        <= next_fmt_out[2];
      capture_rising      <= next_fmt_out[3];
      coarse_gain_high    <= next_fmt_out[4];
      lsb_first           <= next_fmt_out[5];
      bitwise_split       <= next_fmt_out[6];
      data_drive_half_ma  <= data_drv.half_ma;
      clock_drive_half_ma <= clock_drv.half_ma;
      clock_term_enable   <= next_term;
    end
  end

endmodule // serial_output_format_config

// File: serial_output_format_config_sva.sv
// Checker for the serial output format configuration block.
// Assumes it sees only the top module ports; attached by bind below.
`timescale 1ns/1ps
module serial_output_format_config_sva
  import serial_output_format_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       two_wire,
  input wire logic       sdr_bit_clock,
  input wire logic       capture_rising,
  input wire logic       bitwise_split,
  input wire logic [4:0] data_drive_half_ma,
  input wire logic [4:0] clock_drive_half_ma
);
  ////////////////////////////////////////////////////////////////////////////
  // One clock domain, so clocking and disable are declared once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write address and data taken together, and a read request taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Reset check must run while reset is low, so it is never disabled
  a_reset_nominal: assert property (disable iff (1'b0)
    !aresetn |=> data_drive_half_ma == 5'h07 && clock_drive_half_ma == 5'h07)
    else $error("drive current not nominal after reset");
  a_sdr_two_wire: assert property (sdr_bit_clock |-> two_wire)
    else $error("sdr clock without two-wire mode");
  a_rising_sdr: assert property (capture_rising |-> sdr_bit_clock)
    else $error("capture edge select without sdr clock");
  a_split_two_wire: assert property (bitwise_split |-> two_wire)
    else $error("bit-wise split without two-wire mode");
  a_data_cur_legal: assert property (data_drive_half_ma inside
    {5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10})
    else $error("data drive current off the code table");
  a_clk_cur_legal: assert property (clock_drive_half_ma inside
    {5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10})
    else $error("clock drive current off the code table");
  a_write_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
    else $error("write response missing two cycles after both halves");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data missing one cycle after request");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
endmodule // serial_output_format_config_sva

bind serial_output_format_config serial_output_format_config_sva u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .two_wire, .sdr_bit_clock, .capture_rising,
  .bitwise_split, .data_drive_half_ma, .clock_drive_half_ma
);

// File: serial_output_format_pkg.sv
// Constants shared by the serial output format configuration block.
// Assumes a 32-bit AXI4-Lite register bus; each register is one word.
//
// Functional notes
// - Hardware or software reset clears both registers
// - D0 picks lanes; D1 SDR only two-wire
// - SDR clock: D4 picks falling or rising capture
// - D6 picks MSB-first or LSB-first order
// - D7 byte-wise or bit-wise, two-wire only
// - D5 selects 0 dB or 3.5 dB gain
// - Override bit D10 lets register beat pins
// - Doubler bits double data or clock current
// - D3-D2 code sets data drive current
// - D5-D4 same coding for clock drive current
// - D10-D6 clock termination resistor enables, one bit per resistor
// - Several termination bits give resistors in parallel
package serial_output_format_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SOFT_RESET  = 8'h00;
  localparam logic [7:0] IDX_FORMAT      = 8'h0d;
  localparam logic [7:0] IDX_DRIVE       = 8'h10;
  localparam logic [7:0] IDX_STATUS      = 8'h1f;
  localparam int         ADDR_W          = 12;
  localparam int         REG_W           = 11;

  // Reset values and writable masks
  localparam logic [10:0] FORMAT_RESET   = 11'h000;
  localparam logic [10:0] DRIVE_RESET    = 11'h000;
  localparam logic [10:0] FORMAT_WMASK   = 11'h4f7;
  localparam logic [10:0] DRIVE_WMASK    = 11'h7ff;

  // Output format register fields
  localparam int FMT_TWO_WIRE  = 0;
  localparam int FMT_SDR       = 1;
  localparam int FMT_SER16     = 2;
  localparam int FMT_RISING    = 4;
  localparam int FMT_GAIN      = 5;
  localparam int FMT_LSB_FIRST = 6;
  localparam int FMT_BITWISE   = 7;
  localparam int FMT_OVERRIDE  = 10;
  localparam int PIN_W         = 8;

  // Output buffer drive register fields
  localparam int DRV_DATA_DBL  = 0;
  localparam int DRV_CLK_DBL   = 1;
  localparam int DRV_DATA_LO   = 2;
  localparam int DRV_CLK_LO    = 4;
  localparam int DRV_TERM_LO   = 6;
  localparam int TERM_N        = 5;

  // Soft reset bit and status fields
  localparam int SRST_BIT      = 10;
  localparam int STS_OVERRIDE  = 8;
  localparam int STS_LINK_SEEN = 9;

  // Nominal drive current per code, in half milliamps
  localparam logic [4:0] CUR_CODE0 = 5'h07;
  localparam logic [4:0] CUR_CODE1 = 5'h08;
  localparam logic [4:0] CUR_CODE2 = 5'h05;
  localparam logic [4:0] CUR_CODE3 = 5'h06;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: tb_serial_output_format_config.sv
// Self-checking bench for the serial output format configuration block.
// Assumes the checker is bound in and the link clock model is compiled.
`timescale 1ns/1ps
module tb_serial_output_format_config
  import serial_output_format_pkg::*;
;
  logic              aclk = 1'b0, aresetn = 1'b0;         // Clock, reset
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0; // Addresses
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;                   // Whole words, except the lane 0 strobe test
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [PIN_W-1:0]  format_pins = '0;                     // Parallel pins
  logic              link_clk, link_run = 1'b0;
  logic              two_wire, sdr_bit_clock, serialize_16, capture_rising;
  logic              coarse_gain_high, lsb_first, bitwise_split;
  logic [4:0]        data_drive_half_ma, clock_drive_half_ma;
  logic [TERM_N-1:0] clock_term_enable;
  logic [6:0]        outs;                                 // Format outputs
  int                fail_count = 0, n_compared = 0;

  assign outs = {two_wire, sdr_bit_clock, serialize_16, capture_rising,
                 coarse_gain_high, lsb_first, bitwise_split};

  always #4 aclk = ~aclk;

  serial_output_format_config DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .format_pins, .link_clk, .two_wire, .sdr_bit_clock,
    .serialize_16, .capture_rising, .coarse_gain_high, .lsb_first,
    .bitwise_split, .data_drive_half_ma, .clock_drive_half_ma,
    .clock_term_enable);
  link_clock_source u_link (.run(link_run), .link_clk(link_clk));

  ////////////////////////////////////////////////////////////////////////////
  // Expected format outputs; sdr, edge and split only count in two-wire
  function automatic logic [6:0] fmt_out(input logic [7:0] f);
    return {f[0], f[0] & f[1], f[2], f[0] & f[1] & f[4], f[5], f[6],
            f[0] & f[7]};
  endfunction
  // Expected current in half milliamps for a code and doubler
  function automatic logic [4:0] cur(input logic [1:0] c, input logic d);
    logic [4:0] n;
    n = (c == 2'h0) ? 5'h07 : (c == 2'h1) ? 5'h08 : (c == 2'h2) ? 5'h05 : 5'h06;
    return d ? n << 1 : n;
  endfunction

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask

  // Handshakes are judged on values seen at the falling edge, which
  // hold until the next rising edge since inputs only move there
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, bv, b;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      b = bv && s_axi_bready;
      if (b) chk("bresp", (a == 12'h034 || a == 12'h040 || a == 12'h000)
                 ? RESP_OKAY : RESP_SLVERR, s_axi_bresp);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !b;
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic ar, rv, h;
    h = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!h) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      h = rv && s_axi_rready;
      d = s_axi_rdata;
      if (h) chk("rresp", (a == 12'h050) ? RESP_SLVERR : RESP_OKAY, s_axi_rresp);
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !h;
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, format, drive, unmapped, link, resets
  initial begin
    logic [31:0] d;
    logic [10:0] f;
    logic [7:0]  p, e;
    int          i;
    void'($urandom(32'hbb90a7a6));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h034, d);
    chk("format reset", 0, d);
    rd(12'h040, d);
    chk("drive reset", 0, d);
    $display("test reset values done");
    for (i = 0; i < 16; i++) begin
      f = {i[0], 10'($urandom)};
      if (i == 3) f = 11'h7ff;
      p = 8'($urandom);
      wr(12'h034, 32'(f));
      format_pins <= p;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      e = f[10] ? f[7:0] : p;
      chk("format outputs", fmt_out(e), outs);
      @(posedge aclk);
      rd(12'h034, d);
      chk("format read", f & 11'h4f7, d);
      rd(12'h07c, d);
      chk("status", {f[10], e & 8'hf7}, d[8:0] & 9'h1f7);
    end
    $display("test format and override done");
    for (i = 0; i < 16; i++) begin
      f = 11'($urandom);
      f[5:2] = 4'(i);
      if (i == 5) f[10:6] = 5'b00101;
      wr(12'h040, 32'(f));
      @(negedge aclk);
      chk("data current", cur(f[3:2], f[0]), data_drive_half_ma);
      chk("clock current", cur(f[5:4], f[1]), clock_drive_half_ma);
      chk("termination", f[10:6], clock_term_enable);
      @(posedge aclk);
      rd(12'h040, d);
      chk("drive read", f, d);
    end
    // Lane 0 only: bits 10:8 keep, and soft reset needs lane 1
    s_axi_wstrb <= 4'h1;
    wr(12'h040, 32'h0);
    wr(12'h000, 32'h400);
    s_axi_wstrb <= 4'hf;
    rd(12'h040, d);
    chk("strobe lanes", {f[10:8], 8'h00}, d);
    $display("test drive done");
    wr(12'h050, 32'h7ff);
    rd(12'h050, d);
    chk("unmapped read", 0, d);
    $display("test unmapped done");
    link_run <= 1'b1;
    repeat (40) @(posedge aclk);
    link_run <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(12'h07c, d);
    chk("link seen", 1, d[9]);
    for (i = 0; i < 2; i++) begin
      wr(12'h034, 32'h7ff);
      wr(12'h040, 32'h7ff);
      if (i == 0) begin
        wr(12'h000, 32'h400);
      end else begin
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
      end
      rd(12'h034, d);
      chk("format cleared", 0, d);
      rd(12'h040, d);
      chk("drive cleared", 0, d);
      chk("drive nominal", CUR_CODE0, data_drive_half_ma);
      rd(12'h07c, d);
      chk("link cleared", 0, d[9]);
    end
    $display("test link and resets done");
    conclude();
  end

  // Watchdog: the tests need well under 100 us
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // tb_serial_output_format_config
